// ===== verilog/sacs_defines.svh
// shared constants of the conversion sequencer
`ifndef SACS_DEFINES_SVH
`define SACS_DEFINES_SVH
`define SACS_RES_W        13
`define SACS_CNT_W        5
`define SACS_ACQ_HALVES   5'h03
`define SACS_CONV_BITS    5'h0D
`define SACS_CFG_BITS     5'h05
`define SACS_CODE_POS_MAX 13'h0FFF
`define SACS_CODE_NEG_MAX 13'h1000
`define SACS_CODE_POS_1   13'h0001
`define SACS_HOLD_NS      1200000
`define SACS_CLK_NS       10
`define SACS_HOLD_CYC     (`SACS_HOLD_NS / `SACS_CLK_NS)
`endif

// ===== verilog/sacs_pkg.sv
// types of the conversion sequencer
package sacs_pkg;
	typedef enum logic [2:0] {ST_IDLE, ST_CFG, ST_ACQ, ST_CONV, ST_DONE} sacs_state_t;
	typedef struct packed {
		logic        valid;
		logic [12:0] code;
	} sacs_word_t;
endpackage : sacs_pkg

// ===== verilog/sacs_seq.sv
// conversion sequencer with a two-entry result buffer
`timescale 1ns/1ps
`include "sacs_defines.svh"

module sacs_seq (
	input  wire logic        core_clk_in,          // system clock, 100 MHz
	input  wire logic        nrst_in,              // async reset, active low
	input  wire logic        select_and_standby_n_in, // session select pin, active low
	input  wire logic        sclk_in,              // serial clock pin from host
	input  wire logic        sdi_in,               // serial config data pin
	input  wire logic        comp_in,              // comparator: trial <= held input
	output logic             sdo_out,              // serial data out level
	output logic             sdo_oe_n_out,         // low while sdo is driven
	output logic             hold_capacitor_out,   // high while sampling
	output logic [12:0]      trial_out,            // dac trial code
	output logic [`SACS_CFG_BITS-1:0] cfg_out,     // captured configuration bits
	output sacs_pkg::sacs_word_t res_out,          // finished result word
	input  wire logic        res_ready_in,         // consumer accepts result
	output logic             hold_err_out          // hold interval exceeded
);
	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	logic [2:0] cs_sy_r;    // select pipeline
	logic [2:0] ck_sy_r;    // clock pipeline
	logic [2:0] di_sy_r;    // data pipeline
	logic       cs_n_r;     // filtered select
	logic       ck_r;       // filtered clock
	logic       di_r;       // filtered data

	// three stages; a change counts once stages two and three agree
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cs_sy_r <= 3'h7;
			ck_sy_r <= 3'h0;
			di_sy_r <= 3'h0;
		end
		else
		begin
			cs_sy_r <= {cs_sy_r[1:0], select_and_standby_n_in};
			ck_sy_r <= {ck_sy_r[1:0], sclk_in};
			di_sy_r <= {di_sy_r[1:0], sdi_in};
		end
	end

	// filtered levels
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cs_n_r <= 1'b1;
			ck_r   <= 1'b0;
			di_r   <= 1'b0;
		end
		else
		begin
			if (cs_sy_r[1] == cs_sy_r[2])
				cs_n_r <= cs_sy_r[2];
			if (ck_sy_r[1] == ck_sy_r[2])
				ck_r <= ck_sy_r[2];
			if (di_sy_r[1] == di_sy_r[2])
				di_r <= di_sy_r[2];
		end
	end

	// edge detection on the filtered clock only
	logic ck_agree;   // stages two and three agree
	logic ck_rise;    // filtered rising edge
	logic ck_fall;    // filtered falling edge
	assign ck_agree = (ck_sy_r[1] == ck_sy_r[2]);
	assign ck_rise  = ck_agree && ck_sy_r[2] && !ck_r;
	assign ck_fall  = ck_agree && !ck_sy_r[2] && ck_r;
	logic cs_open;    // session active
	assign cs_open = !cs_n_r;

	// ----------------------------------------
	// sequencing state
	// ----------------------------------------
	sacs_pkg::sacs_state_t state_r; // sequence state
	logic [`SACS_CNT_W-1:0] cnt_r;  // half-clock or bit counter
	logic [12:0] code_r;            // successive approximation register
	logic [12:0] bit_r;             // one-hot trial bit

	// first bit trial: sign resolves as a comparison against zero
	// the sign weight itself would be the most negative code and could never fail
	function automatic logic [12:0] trial_of(input logic [12:0] code, input logic [12:0] bitm);
		if (bitm == 13'h1000)
			trial_of = 13'h0000; // sign trial against zero
		else
			trial_of = code | bitm; // magnitude trial on top of kept bits
	endfunction : trial_of

	// past ST_IDLE all progress is gated by serial edges; no free-running timer moves the state
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			state_r <= sacs_pkg::ST_IDLE;
			cnt_r   <= '0;
		end
		else if (!cs_open)
		begin
			state_r <= sacs_pkg::ST_IDLE;
			cnt_r   <= '0;
		end
		else
		begin
			case (state_r)
				sacs_pkg::ST_IDLE:
				begin
					state_r <= sacs_pkg::ST_CFG;
					cnt_r   <= '0;
				end
				sacs_pkg::ST_CFG:
				begin
					// configuration bits clocked in on rising edges
					if (ck_rise)
					begin
						if (cnt_r == `SACS_CFG_BITS - 5'h01)
						begin
							state_r <= sacs_pkg::ST_ACQ;
							cnt_r   <= '0;
						end
						else
							cnt_r <= cnt_r + 5'h01;
					end
				end
				sacs_pkg::ST_ACQ:
				begin
					// count half periods: 1.5 clocks of sampling
					if (ck_rise || ck_fall)
					begin
						if (cnt_r == `SACS_ACQ_HALVES - 5'h01)
						begin
							state_r <= sacs_pkg::ST_CONV;
							cnt_r   <= '0;
						end
						else
							cnt_r <= cnt_r + 5'h01;
					end
				end
				sacs_pkg::ST_CONV:
				begin
					// one resolved bit per falling edge
					if (ck_fall)
					begin
						if (cnt_r == `SACS_CONV_BITS - 5'h01)
						begin
							state_r <= sacs_pkg::ST_DONE;
							cnt_r   <= '0;
						end
						else
							cnt_r <= cnt_r + 5'h01;
					end
				end
				sacs_pkg::ST_DONE:
					state_r <= sacs_pkg::ST_DONE;
				default:
					state_r <= sacs_pkg::ST_IDLE;
			endcase
		end
	end

	// configuration shift on rising serial edges
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			cfg_out <= '0;
		else if (state_r == sacs_pkg::ST_CFG && cs_open && ck_rise)
			cfg_out <= {cfg_out[`SACS_CFG_BITS-2:0], di_r};
	end

	// successive approximation, msb (sign) first
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			code_r <= '0;
			bit_r  <= '0;
		end
		else if (state_r == sacs_pkg::ST_ACQ)
		begin
			code_r <= '0;
			bit_r  <= 13'h1000; // sign position first
		end
		else if (state_r == sacs_pkg::ST_CONV && cs_open && ck_fall)
		begin
			// sign bit: one when negative input higher; magnitude bits kept when trial fits
			if (bit_r == 13'h1000)
				code_r <= comp_in ? 13'h0000 : 13'h1000;
			else if (comp_in)
				code_r <= code_r | bit_r;
			bit_r <= bit_r >> 1;
		end
	end
	assign trial_out = trial_of(code_r, bit_r);

	// serial output updates on falling edges only; forced low outside sessions
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			sdo_out <= 1'b0;
		else if (!cs_open)
			sdo_out <= 1'b0;
		else if (state_r == sacs_pkg::ST_CONV && ck_fall)
		begin
			if (bit_r == 13'h1000)
				sdo_out <= !comp_in;
			else
				sdo_out <= comp_in;
		end
	end
	assign sdo_oe_n_out      = !(cs_open && (state_r == sacs_pkg::ST_CONV || state_r == sacs_pkg::ST_DONE));
	assign hold_capacitor_out = cs_open && (state_r == sacs_pkg::ST_ACQ);

	// ----------------------------------------
	// hold interval watchdog
	// ----------------------------------------
	logic [17:0] hold_cnt_r;  // cycles since acquisition ended
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			hold_cnt_r   <= '0;
			hold_err_out <= 1'b0;
		end
		else if (state_r != sacs_pkg::ST_CONV)
			hold_cnt_r <= '0;
		else if (hold_cnt_r != 18'(`SACS_HOLD_CYC))
			hold_cnt_r <= hold_cnt_r + 18'h00001;
		else
			hold_err_out <= 1'b1; // flags late host; sticky until reset
	end

	// ----------------------------------------
	// two-entry result buffer
	// ----------------------------------------
	logic [12:0] buf_r [0:1]; // stored words
	logic [1:0]  cnt_b_r;     // fill level
	logic        rd_r;        // read pointer
	logic        push;        // finished word offered
	logic        pop;         // consumer takes head
	sacs_pkg::sacs_state_t state_d_r; // previous state
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
			state_d_r <= sacs_pkg::ST_IDLE;
		else
			state_d_r <= state_r;
	end
	// a full buffer drops the new word; the stall cannot reach the host pins
	assign push = (state_r == sacs_pkg::ST_DONE) && (state_d_r != sacs_pkg::ST_DONE) && (cnt_b_r != 2'h2);
	assign pop  = res_out.valid && res_ready_in;
	always_ff @(posedge core_clk_in or negedge nrst_in)
	begin
		if (!nrst_in)
		begin
			cnt_b_r <= '0;
			rd_r    <= 1'b0;
		end
		else
		begin
			if (pop)
				rd_r <= !rd_r;
			cnt_b_r <= cnt_b_r + {1'b0, push} - {1'b0, pop};
		end
	end
	// storage has no reset: a word only counts once the fill level covers it
	always_ff @(posedge core_clk_in)
	begin
		if (push)
			buf_r[rd_r ^ cnt_b_r[0]] <= code_r;
	end
	// one driver for the whole word keeps valid and code together
	assign res_out = {(cnt_b_r != 2'h0), buf_r[rd_r]};

	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence s_acq_end;
		state_r == sacs_pkg::ST_ACQ ##1 state_r == sacs_pkg::ST_CONV;
	endsequence
	a_acq_to_conv: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		s_acq_end |-> cnt_r == 5'h00 && bit_r == 13'h1000 && !hold_capacitor_out)
		else $error("conversion did not start clean");
	a_conv_stalls: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(state_r == sacs_pkg::ST_CONV && !ck_fall && cs_open) |=> $stable(cnt_r))
		else $error("bit advanced without clock");
	a_sdo_on_fall: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(cs_open && !ck_fall) |=> $stable(sdo_out) || !cs_open)
		else $error("sdo changed off falling edge");
	a_cs_ends: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		!cs_open |=> state_r == sacs_pkg::ST_IDLE)
		else $error("standby not entered");
	a_done_holds: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(state_r == sacs_pkg::ST_DONE && cs_open) |=> $stable(sdo_out) && $stable(code_r))
		else $error("output moved after end");
	a_hold_sample: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		$rose(hold_capacitor_out) |-> $past(ck_rise) && $past(state_r) == sacs_pkg::ST_CFG)
		else $error("sampling not opened by a rising clock");
	a_cfg_rise: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(!ck_rise) |=> $stable(cfg_out))
		else $error("config changed off rising edge");
	a_thirteen: assert property (@(posedge core_clk_in) disable iff (!nrst_in)
		(state_r == sacs_pkg::ST_CONV ##1 state_r == sacs_pkg::ST_DONE) |-> $past(cnt_r) == 5'h0C)
		else $error("not thirteen bits");
endmodule : sacs_seq

// ===== verif/sacs_host.sv
// host controller model: drives select, serial clock and config data
`timescale 1ns/1ps
module sacs_host (
	input  wire logic clk_in,      // core clock, pins change on its falling edge
	input  wire logic sdo_in,      // serial result from the device
	input  wire logic sdo_oe_n_in, // low while the result is driven
	output logic      sel_n_out,   // session select, active low
	output logic      sclk_out,    // serial clock, stands still outside sessions
	output logic      sdi_out      // configuration data
);
	logic [12:0] bits_r;  // captured result, msb first
	logic        stopped; // high while the serial clock is held still
	// ----------------------------------------
	// pin start values
	// ----------------------------------------
	initial
	begin
		sel_n_out = 1'b1;
		sclk_out  = 1'b0;
		sdi_out   = 1'b0;
		stopped   = 1'b0;
		bits_r    = 13'h0000;
	end
	task automatic wt(input int n);
		repeat (n) @(negedge clk_in);
	endtask : wt
	// one session: five config bits, then nclk clocks with halves hi and lo
	task automatic run(input logic [4:0] cfg, input int nclk, hi, lo, stop_at, stop_len);
		sel_n_out = 1'b0;
		wt(8);
		for (int i = 0; i < 5; i++)
		begin
			sdi_out = cfg[4-i];
			wt(lo);
			sclk_out = 1'b1;
			wt(hi);
			sclk_out = 1'b0;
			sdi_out  = ~sdi_out; // line no longer meaningful: keep it moving
		end
		for (int k = 0; k < nclk; k++)
		begin
			wt(lo);
			sclk_out = 1'b1;
			// bits come after each conversion fall, so sample on the next rise
			if (k >= 2 && k <= 14)
				bits_r = {bits_r[11:0], sdo_oe_n_in ? 1'bx : sdo_in};
			wt(hi);
			sclk_out = 1'b0;
			sdi_out  = ~sdi_out;
			if (k == stop_at)
			begin
				wt(8); // let the last falling edge reach the device first
				stopped = 1'b1;
				wt(stop_len);
				stopped = 1'b0;
			end
		end
		wt(8);
		sel_n_out = 1'b1;
		wt(12);
	endtask : run
endmodule : sacs_host

// ===== verif/sacs_seq_tb.sv
// self-checking bench of the conversion sequencer
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin mismatches++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module sacs_seq_tb;
	logic                 clk = 1'b0;      // core clock
	logic                 nrst_n = 1'b0;   // reset, active low
	logic                 sel_n, sclk, sdi; // host pins
	logic                 sdo, oe_n, hold, err;
	logic                 ready = 1'b0;    // result consumer
	logic [12:0]          trial, trial_q, target = 13'h0000;
	logic [4:0]           cfg;
	sacs_pkg::sacs_word_t res;
	int                   mismatches = 0, n_tests = 0, hold_cyc = 0;
	wire                  comp = ($signed(trial) <= $signed(target)); // ideal comparator
	always #5 clk = ~clk;
	sacs_seq dut_u (.core_clk_in(clk), .nrst_in(nrst_n), .select_and_standby_n_in(sel_n),
		.sclk_in(sclk), .sdi_in(sdi), .comp_in(comp), .sdo_out(sdo), .sdo_oe_n_out(oe_n),
		.hold_capacitor_out(hold), .trial_out(trial), .cfg_out(cfg), .res_out(res),
		.res_ready_in(ready), .hold_err_out(err));
	sacs_host host_u (.clk_in(clk), .sdo_in(sdo), .sdo_oe_n_in(oe_n), .sel_n_out(sel_n),
		.sclk_out(sclk), .sdi_out(sdi));
	// ----------------------------------------
	// monitors: sampling length, no progress while the clock stands
	// ----------------------------------------
	always @(posedge clk)
	begin
		if (hold === 1'b1)
			hold_cyc++;
		if (host_u.stopped)
			`CHK(trial, trial_q)
		trial_q <= trial;
	end
	task automatic pop();
		@(negedge clk) ready = 1'b1;
		@(negedge clk) ready = 1'b0;
	endtask : pop
	// one conversion, checking the wire result and the sampling span
	task automatic conv(input logic [12:0] code, input logic [4:0] c, input int nclk, hi, lo, sa, sl);
		target   = code;
		hold_cyc = 0;
		host_u.run(c, nclk, hi, lo, sa, sl);
		`CHK(host_u.bits_r, code)
		`CHK(host_u.bits_r[12], code[12])
		`CHK(cfg, c)
		`CHK((hold_cyc >= 2*hi+lo-3 && hold_cyc <= 2*hi+lo+3), 1'b1)
	endtask : conv
	// boundary codes, both signs, extra clocks after the last bit
	task automatic t_codes();
		logic [12:0] tbl [5] = '{13'h0FFF, 13'h1000, 13'h0001, 13'h0000, 13'h1A5A};
		foreach (tbl[i])
		begin
			conv(tbl[i], 5'h15 ^ 5'(i), 18, 20, 20, -1, 0);
			`CHK(res, {1'b1, tbl[i]})
			pop();
		end
		$display("test codes done");
	endtask : t_codes
	// uneven duty and a long clock stop mid-conversion
	task automatic t_stop();
		conv(13'h0ABC, 5'h0A, 15, 12, 30, 6, 2000);
		`CHK(res, {1'b1, 13'h0ABC})
		pop();
		$display("test stop done");
	endtask : t_stop
	// select raised mid-conversion ends the session with no word
	task automatic t_abort();
		target = 13'h0123;
		host_u.run(5'h1F, 7, 20, 20, -1, 0);
		`CHK(res.valid, 1'b0)
		`CHK(oe_n, 1'b1)
		$display("test abort done");
	endtask : t_abort
	// consumer stalls: two words kept, third dropped, then drained
	task automatic t_buffer();
		conv(13'h0111, 5'h01, 15, 20, 20, -1, 0);
		conv(13'h1222, 5'h02, 15, 20, 20, -1, 0);
		conv(13'h0333, 5'h03, 15, 20, 20, -1, 0);
		`CHK(res, {1'b1, 13'h0111})
		pop();
		`CHK(res, {1'b1, 13'h1222})
		pop();
		`CHK(res.valid, 1'b0)
		`CHK(err, 1'b0)
		$display("test buffer done");
	endtask : t_buffer
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : complete_run
	// ----------------------------------------
	// main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		repeat (6) @(negedge clk);
		nrst_n = 1'b1;
		repeat (4) @(negedge clk);
		t_codes();
		t_stop();
		t_abort();
		t_buffer();
		complete_run();
	end
	initial
	begin
		#300000;
		mismatches++;
		complete_run();
	end
endmodule : sacs_seq_tb
